// ===== sp_serial_port.sv
// serial port interrupt, timer, clock polarity and status flag logic
// Behaviour
// R1 - quiet-line interrupt when enabled and flag sets
// R2 - acknowledge clears; rearm after a character
// R3 - receive request when enabled and holding full
// R4 - error flags pick the exception vector
// R5 - transmit request when enabled and holding empty
// R6 - timer request every 16 serial clocks
// R7 - extra divide by 32 unless bypassed
// R8 - timer works without any pin setup
// R9 - polarity bit inverts clock both ways
// R10 - flags register eight bits, read only
// R11 - all-empty set when both transmit registers empty
// R12 - all-empty cleared by write or sequence
// R13 - holding-empty set when empty, cleared on write
// R14 - sync mode: empty mid second bit
// R15 - external clock stopped holds the flag off
// R16 - async: empty two 16x ticks into data
// R17 - holding-full on transfer, cleared by read
// R18 - quiet flag after 10/11 ones, start clears
// R19 - overrun when full; new byte dropped
// R20 - overrun clears frame and parity flags
// R21 - parity error with transfer, does not block
// R22 - parity reads zero without parity format
// R23 - frame error blocks transfers until cleared
// R24 - status read arms clearing of seen errors
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module sp_serial_port
  import sp_pkg::*;
(
  input wire logic sys_clk, // system clock, 250 MHz
  input wire logic sys_rst, // synchronous hardware/software reset
  input wire logic port_rst, // individual or stop reset: flags and holding registers, not control
  input wire sp_bus_req_s bus_req, // register strobes, address, data
  output logic [DATA_W-1:0] bus_rdata_reg, // read data, cycle after read
  input wire sp_rx_evt_s rx_evt, // character from receive shifter
  input wire logic rx_start_det, // start bit detected pulse
  input wire logic rx_bit_tick, // one pulse per received bit time
  input wire logic rx_bit_val, // received line level at that tick
  input wire logic tx_shift_load, // shifter took the holding word
  input wire logic tx_shift_empty, // shifter holds no data
  input wire logic tx_tick, // 16x tick async, 2x tick sync
  input wire logic tx_seq_sent, // idle, preamble or break sent
  input wire logic int_clk_tick, // internal serial clock pulse
  input wire logic sclk_core_out, // clock made by the baud generator
  input wire logic sclk_pin_in, // level on the serial clock pin
  input wire logic quiet_ack, // acknowledge of quiet-line request
  input wire logic timer_ack, // acknowledge of timer request
  output logic [CHAR_W-1:0] tx_data_reg, // word for the shifter
  output logic tx_addr_flag_reg, // word came via address location
  output logic tx_data_avail_reg, // holding word awaits the shifter
  output logic [CHAR_W-1:0] rx_holding_reg, // received character
  output logic sclk_pin_out_reg, // clock driven to the pin
  output logic sclk_core_in_reg, // pin clock as seen by the core
  output logic quiet_line_int_req, // quiet-line interrupt request
  output logic rx_int_req_reg, // receive without exception
  output logic rx_exc_req_reg, // receive with exception
  output logic tx_int_req_reg, // transmit interrupt request
  output logic timer_int_req // periodic timer request
);
  logic [DATA_W-1:0] serial_control_reg;
  logic [2:0] wds;
  logic quiet_line_int_en, rx_int_en, tx_int_en;
  logic periodic_int_en, timer_rate_bypass, clk_polarity_sel;
  logic flag_rst;
  logic wr_ctrl, wr_txh, wr_txha, wr_tx, rd_flags, rd_rxh;

  assign flag_rst = sys_rst || port_rst;
  assign wds = serial_control_reg[CB_WDS_HI:CB_WDS_LO];
  assign quiet_line_int_en = serial_control_reg[CB_QUIET_EN];
  assign rx_int_en = serial_control_reg[CB_RX_INT_EN];
  assign tx_int_en = serial_control_reg[CB_TX_INT_EN];
  assign periodic_int_en = serial_control_reg[CB_PER_EN];
  assign timer_rate_bypass = serial_control_reg[CB_RATE];
  assign clk_polarity_sel = serial_control_reg[CB_POL];

  assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
  assign wr_txh = bus_req.wr && (bus_req.addr == OFS_TXH);
  assign wr_txha = bus_req.wr && (bus_req.addr == OFS_TXHA);
  assign wr_tx = wr_txh || wr_txha;
  assign rd_flags = bus_req.rd && (bus_req.addr == OFS_FLAGS);
  assign rd_rxh = bus_req.rd && (bus_req.addr == OFS_RXH);

  // enables and mode bits are cleared only by hardware/software reset
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      serial_control_reg <= CTRL_RST; // R1 R3 R5 R6 R7 R9
    end else if (wr_ctrl) begin
      serial_control_reg <= bus_req.wdata;
    end
  end

  // ---------------- transmit side
  sp_tx_state_e tx_state_reg;
  logic [4:0] tx_cnt_reg;
  logic tx_holding_empty, tx_all_empty;
  logic [4:0] tx_ticks;

  assign tx_ticks = (wds == WDS_SYNC8) ? TX_SYNC_TICKS : TX_ASYNC_TICKS;

  // the tick count stalls when an external clock stops, so the flag waits
  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      tx_state_reg <= TX_EMPTY;
      tx_cnt_reg <= '0;
    end else begin
      case (tx_state_reg)
        TX_EMPTY: begin
          if (wr_tx) begin
            tx_state_reg <= TX_FULL; // R13
          end
        end
        TX_FULL: begin
          if (tx_shift_load) begin
            tx_state_reg <= TX_SHIFTING;
            tx_cnt_reg <= '0;
          end
        end
        TX_SHIFTING: begin
          if (wr_tx) begin
            tx_state_reg <= TX_FULL;
          end else if (tx_tick) begin
            if (tx_cnt_reg == tx_ticks - 5'h01) begin
              tx_state_reg <= TX_EMPTY; // R14 R15 R16
            end
            tx_cnt_reg <= tx_cnt_reg + 5'h01;
          end
        end
        default: begin
          tx_state_reg <= TX_EMPTY;
        end
      endcase
    end
  end

  assign tx_holding_empty = (tx_state_reg == TX_EMPTY);

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      tx_all_empty <= 1'b1; // R11
    end else if (wr_tx || tx_seq_sent) begin
      tx_all_empty <= 1'b0; // R12
    end else if (tx_holding_empty && tx_shift_empty) begin
      tx_all_empty <= 1'b1; // R11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      tx_data_reg <= '0;
      tx_addr_flag_reg <= 1'b0;
    end else if (wr_tx) begin
      tx_data_reg <= bus_req.wdata[CHAR_W-1:0];
      tx_addr_flag_reg <= wr_txha;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      tx_data_avail_reg <= 1'b0;
    end else if (wr_tx) begin
      tx_data_avail_reg <= 1'b1;
    end else if (tx_shift_load) begin
      tx_data_avail_reg <= 1'b0;
    end
  end

  // ---------------- receive side
  logic rx_holding_full, quiet_flag, overrun_flag;
  logic parity_err_flag, frame_err_flag, bit8_flag;
  logic [2:0] err_seen_reg;
  logic status_read_reg;
  logic rx_take, rx_over, err_clear;
  logic [3:0] ones_reg;
  logic [3:0] ones_need;

  // a frame error holds the holding register until software clears it
  assign rx_take = rx_evt.ready && serial_control_reg[CB_RX_ON] &&
                   !rx_holding_full && !frame_err_flag; // R23
  assign rx_over = rx_evt.ready && serial_control_reg[CB_RX_ON] &&
                   rx_holding_full; // R19
  assign err_clear = rd_rxh && status_read_reg; // R24

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      rx_holding_reg <= '0;
      bit8_flag <= 1'b0;
    end else if (rx_take) begin
      rx_holding_reg <= rx_evt.data; // R19
      bit8_flag <= rx_evt.bit8;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      rx_holding_full <= 1'b0;
    end else if (rx_take) begin
      rx_holding_full <= 1'b1; // R17
    end else if (rd_rxh) begin
      rx_holding_full <= 1'b0; // R17
    end
  end

  // only errors already shown by a status read are cleared by the next
  // holding read; later ones survive it
  always_ff @(posedge sys_clk) begin
    if (flag_rst || rd_rxh) begin
      status_read_reg <= 1'b0;
      err_seen_reg <= '0;
    end else if (rd_flags) begin
      status_read_reg <= 1'b1; // R24
      err_seen_reg <= {frame_err_flag, parity_err_flag, overrun_flag};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      overrun_flag <= 1'b0;
    end else if (rx_over) begin
      overrun_flag <= 1'b1; // R19
    end else if (err_clear && err_seen_reg[0]) begin
      overrun_flag <= 1'b0; // R20
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst || rx_over) begin
      parity_err_flag <= 1'b0; // R20
    end else if (rx_take && rx_evt.parity_bad && sp_has_parity(wds)) begin
      parity_err_flag <= 1'b1; // R21 R22
    end else if (err_clear && err_seen_reg[1]) begin
      parity_err_flag <= 1'b0; // R21
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst || rx_over) begin
      frame_err_flag <= 1'b0; // R20
    end else if (rx_take && rx_evt.no_stop && (wds != WDS_SYNC8)) begin
      frame_err_flag <= 1'b1; // R23
    end else if (err_clear && err_seen_reg[2]) begin
      frame_err_flag <= 1'b0; // R23
    end
  end

  assign ones_need = sp_is_eleven(wds) ? QUIET_ONES_11 : QUIET_ONES_10;

  // counter saturates so a long idle does not wrap back to busy
  always_ff @(posedge sys_clk) begin
    if (flag_rst || rx_start_det) begin
      ones_reg <= '0;
    end else if (rx_bit_tick) begin
      if (!rx_bit_val) begin
        ones_reg <= '0;
      end else if (ones_reg != ones_need) begin
        ones_reg <= ones_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst || rx_start_det) begin
      quiet_flag <= 1'b0; // R18
    end else if (rx_bit_tick && rx_bit_val &&
                 (ones_reg == ones_need - 4'h1)) begin
      quiet_flag <= 1'b1; // R18
    end
  end

  // ---------------- interrupt requests
  logic quiet_prev_reg, quiet_armed_reg, quiet_rise;

  assign quiet_rise = quiet_flag && !quiet_prev_reg;

  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      quiet_prev_reg <= 1'b0;
    end else begin
      quiet_prev_reg <= quiet_flag;
    end
  end

  // one request per quiet period: rearmed only by a received character
  always_ff @(posedge sys_clk) begin
    if (flag_rst) begin
      quiet_armed_reg <= 1'b1;
    end else if (rx_evt.ready) begin
      quiet_armed_reg <= 1'b1; // R2
    end else if (quiet_rise && quiet_line_int_en) begin
      quiet_armed_reg <= 1'b0; // R2
    end
  end

  always_ff @(posedge sys_clk) begin
    if (flag_rst || !quiet_line_int_en) begin
      quiet_line_int_req <= 1'b0; // R1
    end else if (quiet_rise && quiet_armed_reg) begin
      quiet_line_int_req <= 1'b1; // R1
    end else if (quiet_ack) begin
      quiet_line_int_req <= 1'b0; // R2
    end
  end

  logic any_err;
  assign any_err = parity_err_flag || frame_err_flag || overrun_flag;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rx_int_req_reg <= 1'b0;
      rx_exc_req_reg <= 1'b0;
    end else begin
      rx_int_req_reg <= rx_int_en && rx_holding_full && !any_err; // R3 R4
      rx_exc_req_reg <= rx_int_en && rx_holding_full && any_err; // R3 R4
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tx_int_req_reg <= 1'b0;
    end else begin
      tx_int_req_reg <= tx_int_en && tx_holding_empty; // R5
    end
  end

  sp_timer u_timer (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .periodic_int_en(periodic_int_en),
    .timer_rate_bypass(timer_rate_bypass),
    .int_clk_tick(int_clk_tick),
    .ack(timer_ack),
    .req_reg(timer_int_req)
  );

  // ---------------- clock polarity, both directions
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sclk_pin_out_reg <= 1'b0;
      sclk_core_in_reg <= 1'b0;
    end else begin
      sclk_pin_out_reg <= sclk_core_out ^ clk_polarity_sel; // R9
      sclk_core_in_reg <= sclk_pin_in ^ clk_polarity_sel; // R9
    end
  end

  // ---------------- read port
  logic [CHAR_W-1:0] flags_view;
  assign flags_view = {bit8_flag, frame_err_flag, parity_err_flag,
                       overrun_flag, quiet_flag, rx_holding_full,
                       tx_holding_empty, tx_all_empty};

  // flags sit in the low byte, upper bits zero; writes there are ignored
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !bus_req.rd) begin
      bus_rdata_reg <= '0;
    end else begin
      case (bus_req.addr)
        OFS_CTRL: bus_rdata_reg <= serial_control_reg;
        OFS_FLAGS: bus_rdata_reg <= {8'h00, flags_view}; // R10
        OFS_TXH: bus_rdata_reg <= {8'h00, tx_data_reg};
        OFS_TXHA: bus_rdata_reg <= {8'h00, tx_data_reg};
        OFS_RXH: bus_rdata_reg <= {8'h00, rx_holding_reg};
        default: bus_rdata_reg <= '0;
      endcase
    end
  end

  // ---------------- checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst || port_rst);

  a_quiet_no_en: assert property (!quiet_line_int_en |=> !quiet_line_int_req) // R1
    else $error("quiet request with enable clear");
  a_quiet_once: assert property (quiet_line_int_req && quiet_ack &&
    !rx_evt.ready ##1 !rx_evt.ready[*3] |-> !quiet_line_int_req) // R2
    else $error("quiet request reraised without a character");
  a_rx_vector: assert property (rx_int_en && rx_holding_full && any_err
    |=> rx_exc_req_reg && !rx_int_req_reg) // R3 R4
    else $error("wrong receive vector");
  a_tx_request: assert property (tx_int_en && tx_holding_empty
    |=> tx_int_req_reg) // R5
    else $error("transmit request missing");
  a_pol_invert: assert property (##1 sclk_pin_out_reg ==
    ($past(sclk_core_out) ^ $past(clk_polarity_sel))) // R9
    else $error("clock polarity wrong");
  a_flags_upper: assert property (rd_flags |=> bus_rdata_reg[15:8] == 8'h00
    && bus_rdata_reg[SB_TX_EMPTY] == $past(tx_holding_empty)) // R10
    else $error("flags read malformed");
  a_tx_write_clr: assert property (wr_tx |=> !tx_holding_empty
    && !tx_all_empty) // R12 R13
    else $error("write did not clear transmit flags");
  a_tx_no_early: assert property (tx_shift_load && tx_state_reg == TX_FULL
    && !wr_tx |=> !tx_holding_empty[*2]) // R16
    else $error("holding empty set at shift load");
  a_overrun_keep: assert property (rx_over |=> overrun_flag &&
    !frame_err_flag && !parity_err_flag && $stable(rx_holding_reg)) // R19 R20
    else $error("overrun handling wrong");
  a_parity_zero: assert property (!sp_has_parity(wds) && !parity_err_flag
    |=> !parity_err_flag) // R22
    else $error("parity flag set without parity format");
  a_quiet_start: assert property (rx_start_det |=> !quiet_flag) // R18
    else $error("start bit did not clear quiet flag");
  a_frame_block: assert property (frame_err_flag && !rd_rxh |=>
    $stable(rx_holding_reg)) // R23
    else $error("transfer while frame error set");

  c_quiet_req: cover property (quiet_line_int_req ##1 quiet_ack);
  c_overrun: cover property (rx_over);
  c_tx_cycle: cover property (wr_tx ##[1:40] tx_holding_empty);
  c_err_clear: cover property (rd_flags ##[1:8] err_clear);
endmodule : sp_serial_port

// ===== sp_pkg.sv
// shared constants, encodings and carriers of the serial port status block
package sp_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int CHAR_W = 8;

  // register offsets, one 16-bit word each
  localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_TXH = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_TXHA = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_RXH = 3'h4;

  // control register bit positions
  localparam int CB_WDS_LO = 0;
  localparam int CB_WDS_HI = 2;
  localparam int CB_RX_ON = 8;
  localparam int CB_QUIET_EN = 10;
  localparam int CB_RX_INT_EN = 11;
  localparam int CB_TX_INT_EN = 12;
  localparam int CB_PER_EN = 13;
  localparam int CB_RATE = 14;
  localparam int CB_POL = 15;

  // flags register bit positions
  localparam int SB_ALL_EMPTY = 0;
  localparam int SB_TX_EMPTY = 1;
  localparam int SB_RX_FULL = 2;
  localparam int SB_QUIET = 3;
  localparam int SB_OVERRUN = 4;
  localparam int SB_PARITY = 5;
  localparam int SB_FRAME = 6;
  localparam int SB_BIT8 = 7;

  localparam logic [DATA_W-1:0] CTRL_RST = 16'h0000;
  localparam logic [CHAR_W-1:0] FLAGS_RST = 8'h03;

  // word formats
  localparam logic [2:0] WDS_SYNC8 = 3'h0;
  localparam logic [2:0] WDS_ASYNC10 = 3'h2;
  localparam logic [2:0] WDS_EVEN11 = 3'h4;
  localparam logic [2:0] WDS_ODD11 = 3'h5;
  localparam logic [2:0] WDS_MULTI11 = 3'h6;

  localparam logic [3:0] QUIET_ONES_10 = 4'ha;
  localparam logic [3:0] QUIET_ONES_11 = 4'hb;

  // timer chain: divide by 16, then optional divide by 32
  localparam logic [3:0] TMR_PRE_LAST = 4'hf;
  localparam logic [4:0] TMR_POST_LAST = 5'h1f;

  // ticks from shift load to holding-empty: async 16x start bit plus 2,
  // sync 2x clock to the middle of the second bit
  localparam logic [4:0] TX_ASYNC_TICKS = 5'h12;
  localparam logic [4:0] TX_SYNC_TICKS = 5'h03;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sp_bus_req_s;

  typedef struct packed {
    logic ready;
    logic [CHAR_W-1:0] data;
    logic parity_bad;
    logic no_stop;
    logic bit8;
  } sp_rx_evt_s;

  typedef enum logic [1:0] {TX_EMPTY, TX_FULL, TX_SHIFTING} sp_tx_state_e;

  function automatic logic sp_has_parity(input logic [2:0] wds);
    return (wds == WDS_EVEN11) || (wds == WDS_ODD11);
  endfunction : sp_has_parity

  function automatic logic sp_is_eleven(input logic [2:0] wds);
    return sp_has_parity(wds) || (wds == WDS_MULTI11);
  endfunction : sp_is_eleven
endpackage : sp_pkg

// ===== sp_timer.sv
// periodic timer interrupt generator fed by the internal serial clock
`timescale 1ns/1ps
module sp_timer
  import sp_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic periodic_int_en, // timer interrupt enable
  input wire logic timer_rate_bypass, // skip the divide by 32
  input wire logic int_clk_tick, // one pulse per internal serial clock
  input wire logic ack, // acknowledge from interrupt controller
  output logic req_reg // timer interrupt request
);
  logic [3:0] pre_reg;
  logic [4:0] post_reg;
  logic pre_wrap;
  logic fire;

  // counters run regardless of pin configuration
  assign pre_wrap = int_clk_tick && (pre_reg == TMR_PRE_LAST); // R6 R8
  assign fire = pre_wrap && (timer_rate_bypass ||
                (post_reg == TMR_POST_LAST)); // R7

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pre_reg <= '0;
    end else if (int_clk_tick) begin
      pre_reg <= pre_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || timer_rate_bypass) begin
      post_reg <= '0;
    end else if (pre_wrap) begin
      post_reg <= post_reg + 5'h01;
    end
  end

  // a new period wins over an acknowledge in the same cycle
  always_ff @(posedge sys_clk) begin
    if (sys_rst || !periodic_int_en) begin
      req_reg <= 1'b0;
    end else if (fire) begin
      req_reg <= 1'b1; // R6
    end else if (ack) begin
      req_reg <= 1'b0; // R6
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_timer_ack_clear: assert property (
    req_reg && ack && !fire && periodic_int_en ##1 periodic_int_en
    |-> !req_reg) // R6
    else $error("timer request survived acknowledge");
  a_timer_needs_en: assert property (!periodic_int_en |=> !req_reg) // R6
    else $error("timer request without enable");
endmodule : sp_timer

// ===== sp_irq_partner.sv
// interrupt controller model that answers quiet-line and timer requests
`timescale 1ns/1ps
module sp_irq_partner #(
  parameter int ACK_DELAY = 3
) (
  input wire logic sys_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic quiet_req, // quiet-line request
  input wire logic timer_req, // timer request
  output logic quiet_ack, // one-cycle acknowledge
  output logic timer_ack // one-cycle acknowledge
);
  int q_cnt;
  int t_cnt;
  // vectoring takes a few cycles, so a request stands visibly first
  always_ff @(posedge sys_clk) begin
    quiet_ack <= 1'b0;
    q_cnt <= 0;
    if (!sys_rst && quiet_req && !quiet_ack) begin
      q_cnt <= q_cnt + 1;
      if (q_cnt == ACK_DELAY) begin
        quiet_ack <= 1'b1;
        q_cnt <= 0;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    timer_ack <= 1'b0;
    t_cnt <= 0;
    if (!sys_rst && timer_req && !timer_ack) begin
      t_cnt <= t_cnt + 1;
      if (t_cnt == ACK_DELAY) begin
        timer_ack <= 1'b1;
        t_cnt <= 0;
      end
    end
  end
endmodule : sp_irq_partner

// ===== test_sp_serial_port.sv
// self-checking bench of the serial port status block
`timescale 1ns/1ps
module test_sp_serial_port
  import sp_pkg::*;
;
  typedef struct packed {
    logic [2:0] wds;
    logic p;
    logic f;
    logic [7:0] flags;
    logic exc;
  } sp_row_s;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic port_rst = 1'b0;
  sp_bus_req_s bus_req = '0;
  sp_rx_evt_s rx_evt = '0;
  logic rx_start_det = 1'b0;
  logic rx_bit_tick = 1'b0;
  logic rx_bit_val = 1'b1;
  logic tx_shift_load = 1'b0;
  logic tx_shift_empty = 1'b1;
  logic tx_tick = 1'b0;
  logic tx_seq_sent = 1'b0;
  logic int_clk_tick = 1'b0;
  logic sclk_core_out = 1'b0;
  logic sclk_pin_in = 1'b0;
  logic quiet_ack, timer_ack, quiet_line_int_req, timer_int_req;
  logic rx_int_req_reg, rx_exc_req_reg, tx_int_req_reg, tx_data_avail_reg;
  logic tx_addr_flag_reg, sclk_pin_out_reg, sclk_core_in_reg;
  logic [DATA_W-1:0] bus_rdata_reg;
  logic [CHAR_W-1:0] tx_data_reg, rx_holding_reg;
  int n_errors = 0;
  int comparisons = 0;
  sp_row_s rows [7] = '{
    '{3'h2, 1'b0, 1'b0, 8'h07, 1'b0}, '{3'h4, 1'b1, 1'b0, 8'h27, 1'b1},
    '{3'h5, 1'b1, 1'b0, 8'h27, 1'b1}, '{3'h2, 1'b1, 1'b0, 8'h07, 1'b0},
    '{3'h6, 1'b1, 1'b0, 8'h07, 1'b0}, '{3'h0, 1'b0, 1'b1, 8'h07, 1'b0},
    '{3'h2, 1'b0, 1'b1, 8'h47, 1'b1}};

  sp_serial_port sp_serial_port_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .port_rst(port_rst), .bus_req(bus_req), .bus_rdata_reg(bus_rdata_reg),
    .rx_evt(rx_evt), .rx_start_det(rx_start_det), .rx_bit_tick(rx_bit_tick),
    .rx_bit_val(rx_bit_val), .tx_shift_load(tx_shift_load),
    .tx_shift_empty(tx_shift_empty), .tx_tick(tx_tick),
    .tx_seq_sent(tx_seq_sent), .int_clk_tick(int_clk_tick),
    .sclk_core_out(sclk_core_out), .sclk_pin_in(sclk_pin_in),
    .quiet_ack(quiet_ack), .timer_ack(timer_ack), .tx_data_reg(tx_data_reg),
    .tx_addr_flag_reg(tx_addr_flag_reg),
    .tx_data_avail_reg(tx_data_avail_reg), .rx_holding_reg(rx_holding_reg),
    .sclk_pin_out_reg(sclk_pin_out_reg), .sclk_core_in_reg(sclk_core_in_reg),
    .quiet_line_int_req(quiet_line_int_req), .rx_int_req_reg(rx_int_req_reg),
    .rx_exc_req_reg(rx_exc_req_reg), .tx_int_req_reg(tx_int_req_reg),
    .timer_int_req(timer_int_req));
  sp_irq_partner sp_irq_partner_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .quiet_req(quiet_line_int_req), .timer_req(timer_int_req),
    .quiet_ack(quiet_ack), .timer_ack(timer_ack));

  always #2 sys_clk = ~sys_clk;

  task automatic stop_test();
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    bus_req <= '0;
  endtask : wr
  task automatic chkr(input logic [2:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(bus_rdata_reg, exp);
  endtask : chkr
  task automatic rx_ev(input logic [7:0] d, input logic p, input logic f);
    @(posedge sys_clk);
    rx_evt <= '{ready: 1'b1, data: d, parity_bad: p, no_stop: f, bit8: 1'b0};
    @(posedge sys_clk);
    rx_evt <= '0;
  endtask : rx_ev
  // k selects tx_tick, int_clk_tick or rx_bit_tick; one pulse per two cycles
  task automatic ticks(input int k, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      {rx_bit_tick, int_clk_tick, tx_tick} <= 3'h1 << k;
      @(posedge sys_clk);
      {rx_bit_tick, int_clk_tick, tx_tick} <= 3'h0;
    end
  endtask : ticks

  initial begin
    cyc(20000);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    chkr(OFS_FLAGS, 16'h0003);
    chkr(OFS_CTRL, 16'h0000);
    wr(OFS_FLAGS, 16'h00ff);
    chkr(OFS_FLAGS, 16'h0003);
    chkr(3'h5, 16'h0000);
    // the long chain first, while both timer counters still sit at zero
    wr(OFS_CTRL, 16'h2000);
    ticks(1, 511);
    cyc(2);
    chk(16'(timer_int_req), 16'h0000);
    ticks(1, 1);
    cyc(1);
    chk(16'(timer_int_req), 16'h0001);
    cyc(6);
    chk(16'(timer_int_req), 16'h0000);
    wr(OFS_CTRL, 16'h6000);
    ticks(1, 15);
    cyc(2);
    chk(16'(timer_int_req), 16'h0000);
    ticks(1, 1);
    cyc(1);
    chk(16'(timer_int_req), 16'h0001);
    foreach (rows[i]) begin
      wr(OFS_CTRL, 16'h0900 | 16'(rows[i].wds));
      rx_ev(8'h30 + 8'(i), rows[i].p, rows[i].f);
      cyc(2);
      chk({14'h0, rx_int_req_reg, rx_exc_req_reg},
          {14'h0, ~rows[i].exc, rows[i].exc});
      chkr(OFS_FLAGS, {8'h00, rows[i].flags});
      chkr(OFS_RXH, {8'h00, 8'h30 + 8'(i)});
      chkr(OFS_FLAGS, 16'h0003);
    end
    wr(OFS_CTRL, 16'h0104);
    rx_ev(8'h11, 1'b1, 1'b0);
    chkr(OFS_FLAGS, 16'h0027);
    rx_ev(8'h22, 1'b1, 1'b1);
    chkr(OFS_RXH, 16'h0011);
    chkr(OFS_FLAGS, 16'h0013);
    chkr(OFS_RXH, 16'h0011);
    chkr(OFS_FLAGS, 16'h0003);
    for (int m = 0; m < 2; m++) begin
      wr(OFS_CTRL, m ? 16'h1000 : 16'h1002);
      cyc(2);
      chk(16'(tx_int_req_reg), 16'h0001);
      wr(m ? OFS_TXHA : OFS_TXH, 16'h005a + 16'(m));
      chkr(OFS_FLAGS, 16'h0000);
      chk({5'h0, tx_addr_flag_reg, tx_data_avail_reg, tx_int_req_reg,
           tx_data_reg}, {5'h0, 1'(m), 1'b1, 1'b0, 8'h5a + 8'(m)});
      @(posedge sys_clk);
      tx_shift_load <= 1'b1;
      tx_shift_empty <= 1'b0;
      @(posedge sys_clk);
      tx_shift_load <= 1'b0;
      ticks(0, m ? 2 : 17);
      cyc(20);
      chk(16'(tx_data_avail_reg), 16'h0000);
      chkr(OFS_FLAGS, 16'h0000);
      ticks(0, 1);
      cyc(1);
      chkr(OFS_FLAGS, 16'h0002);
      @(posedge sys_clk);
      tx_shift_empty <= 1'b1;
      cyc(2);
      chkr(OFS_FLAGS, 16'h0003);
    end
    @(posedge sys_clk);
    tx_seq_sent <= 1'b1;
    // the shifter is busy with the sequence, so all-empty stays low
    tx_shift_empty <= 1'b0;
    @(posedge sys_clk);
    tx_seq_sent <= 1'b0;
    cyc(1);
    chkr(OFS_FLAGS, 16'h0002);
    @(posedge sys_clk);
    port_rst <= 1'b1;
    tx_shift_empty <= 1'b1;
    @(posedge sys_clk);
    port_rst <= 1'b0;
    chkr(OFS_FLAGS, 16'h0003);
    chkr(OFS_CTRL, 16'h1000);
    wr(OFS_CTRL, 16'h0402);
    ticks(2, 9);
    cyc(2);
    chk(16'(quiet_line_int_req), 16'h0000);
    ticks(2, 1);
    cyc(2);
    chk(16'(quiet_line_int_req), 16'h0001);
    chkr(OFS_FLAGS, 16'h000b);
    cyc(6);
    chk(16'(quiet_line_int_req), 16'h0000);
    ticks(2, 5);
    cyc(1);
    chk(16'(quiet_line_int_req), 16'h0000);
    @(posedge sys_clk);
    rx_start_det <= 1'b1;
    @(posedge sys_clk);
    rx_start_det <= 1'b0;
    cyc(1);
    chkr(OFS_FLAGS, 16'h0003);
    // a new quiet period with no character in between must stay silent
    ticks(2, 10);
    cyc(2);
    chk(16'(quiet_line_int_req), 16'h0000);
    wr(OFS_CTRL, 16'h8000);
    cyc(2);
    chk({14'h0, sclk_pin_out_reg, sclk_core_in_reg}, 16'h0003);
    @(posedge sys_clk);
    {sclk_core_out, sclk_pin_in} <= 2'b11;
    cyc(2);
    chk({14'h0, sclk_pin_out_reg, sclk_core_in_reg}, 16'h0000);
    stop_test();
  end
endmodule : test_sp_serial_port
